// ===== logic/dcw_cfg_write.sv
// Device configuration write command handler with its setup register
// Operation
// - Code D2h plus one byte writes configuration
// - Store only if high nibble inverts low
// - Read returns zero upper nibble, settings below
// - Busy at code: no ack, drop command
// - Update on rising edge of byte ack
// - New settings take effect at once
// - Update four settings, clear reset indicator
// - Read pointer moves to setup register
// - Reset clears all four settings
// - Device reset sets reset indicator
`timescale 1ns/1ps
`default_nettype none
module dcw_cfg_write
  import dcw_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_N_I,
  // Received bytes and acknowledge timing from the serial host layer
  input wire logic BYTE_VALID_I,
  input wire dcw_byte_type BYTE_I,
  input wire logic ACK_EDGE_I,
  input wire logic STOP_I,
  output logic ACK_O,
  // Device reset command and wire engine state
  input wire logic DEV_RESET_I,
  input wire logic WIRE_BUSY_I,
  // Settings and status seen by the rest of the device
  output logic LINE_SPEED_SELECT_O,
  output logic STRONG_PULLUP_ENABLE_O,
  output logic PORT_POWER_DOWN_O,
  output logic ACTIVE_PULLUP_ENABLE_O,
  output logic RESET_IND_O,
  // Read pointer and register read data
  output logic [7:0] READ_PTR_O,
  output logic [7:0] RD_DATA_O
);

  typedef enum logic [1:0] {ST_IDLE, ST_PARAM, ST_COMMIT, ST_DROP} dcw_state_type;

  dcw_state_type state_ff, nxt_state;
  dcw_cfg_type cfg_ff, nxt_cfg;
  logic [3:0] param_ff, nxt_param;
  logic ack_ff, nxt_ack;
  logic rst_ind_ff, nxt_rst_ind;
  logic [7:0] ptr_ff, nxt_ptr;
  logic cmd_hit;
  logic param_good;

  // Decode of the incoming byte
  assign cmd_hit = BYTE_VALID_I && BYTE_I.is_cmd && (BYTE_I.data == DCW_CMD_WRITE_CFG);
  assign param_good = (BYTE_I.data[7:4] == ~BYTE_I.data[3:0]);

  // Next state of the command sequencer and the register
  always_comb begin
    nxt_state = state_ff;
    nxt_cfg = cfg_ff;
    nxt_param = param_ff;
    nxt_ack = ack_ff;
    nxt_rst_ind = rst_ind_ff;
    nxt_ptr = ptr_ff;
    if (ACK_EDGE_I) begin
      nxt_ack = 1'b0;
    end
    case (state_ff)
      ST_IDLE: begin
        if (cmd_hit) begin
          // Wire busy at the code byte refuses the command; busy is not checked at the parameter
          if (WIRE_BUSY_I) begin
            nxt_ack = 1'b0;
            nxt_state = ST_DROP;
          end else begin
            nxt_ack = 1'b1;
            nxt_state = ST_PARAM;
          end
        end
      end
      ST_PARAM: begin
        if (STOP_I) begin
          nxt_state = ST_IDLE;
        end else if (BYTE_VALID_I) begin
          if (!BYTE_I.is_cmd && param_good) begin
            nxt_param = BYTE_I.data[3:0];
            nxt_ack = 1'b1;
            nxt_state = ST_COMMIT;
          end else begin
            nxt_ack = 1'b0;
            nxt_state = ST_DROP;
          end
        end
      end
      ST_COMMIT: begin
        if (ACK_EDGE_I) begin
          // Settings, reset indicator and read pointer change; the wire engine is not started
          nxt_cfg = dcw_cfg_type'(param_ff);
          nxt_rst_ind = 1'b0;
          nxt_ptr = DCW_PTR_CFG;
          nxt_state = ST_IDLE;
        end else if (STOP_I) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_DROP: begin
        // Further bytes of a refused command stay unacknowledged
        nxt_ack = 1'b0;
        if (STOP_I) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Device reset overrides everything but the held parameter, including a write in flight
    if (DEV_RESET_I) begin
      nxt_cfg = dcw_cfg_type'(DCW_CFG_RESET);
      nxt_rst_ind = DCW_RST_IND_RESET;
      nxt_ptr = DCW_PTR_STATUS;
      nxt_ack = 1'b0;
      nxt_state = ST_IDLE;
    end
  end

  // Registers of the sequencer and the setup register
  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      state_ff <= ST_IDLE;
      cfg_ff <= dcw_cfg_type'(DCW_CFG_RESET);
      param_ff <= DCW_CFG_RESET;
      ack_ff <= 1'b0;
      rst_ind_ff <= DCW_RST_IND_RESET;
      ptr_ff <= DCW_PTR_STATUS;
    end else begin
      state_ff <= nxt_state;
      cfg_ff <= nxt_cfg;
      param_ff <= nxt_param;
      ack_ff <= nxt_ack;
      rst_ind_ff <= nxt_rst_ind;
      ptr_ff <= nxt_ptr;
    end
  end

  // Settings drive the device directly from the register
  assign LINE_SPEED_SELECT_O = cfg_ff.line_speed_select;
  assign STRONG_PULLUP_ENABLE_O = cfg_ff.strong_pullup_enable;
  assign PORT_POWER_DOWN_O = cfg_ff.port_power_down;
  assign ACTIVE_PULLUP_ENABLE_O = cfg_ff.active_pullup_enable;
  assign RESET_IND_O = rst_ind_ff;
  assign ACK_O = ack_ff;
  assign READ_PTR_O = ptr_ff;
  assign RD_DATA_O = {DCW_READ_UPPER, cfg_ff};

  default clocking dcw_cb @(posedge CLK_I); endclocking
  default disable iff (!RESET_N_I);

  // Accepted parameter byte, and the commit state meeting its acknowledge edge
  sequence good_param_s;
    BYTE_VALID_I && !BYTE_I.is_cmd && param_good && state_ff == ST_PARAM && !STOP_I
      && !DEV_RESET_I;
  endsequence

  sequence commit_s;
    state_ff == ST_COMMIT && ACK_EDGE_I && !DEV_RESET_I;
  endsequence

  // Code byte on an idle wire is acknowledged and opens the parameter slot
  cmd_ack_a: assert property ((cmd_hit && state_ff == ST_IDLE && !WIRE_BUSY_I
    && !DEV_RESET_I) |=> ACK_O && state_ff == ST_PARAM)
    else $error("configuration command not acknowledged");
  // Busy wire leaves the acknowledge low for the two cycles after the code byte
  busy_nack_a: assert property ((cmd_hit && state_ff == ST_IDLE && WIRE_BUSY_I)
    |=> !ACK_O [*2])
    else $error("command acknowledged while wire busy");
  // Refused command never touches the settings
  drop_stable_a: assert property ((state_ff == ST_DROP && !DEV_RESET_I)
    |=> $stable(cfg_ff) && !ACK_O)
    else $error("refused command changed settings");
  // Malformed parameter is refused
  bad_param_a: assert property ((BYTE_VALID_I && !BYTE_I.is_cmd && !param_good
    && state_ff == ST_PARAM && !STOP_I && !DEV_RESET_I) |=> !ACK_O && state_ff == ST_DROP)
    else $error("malformed parameter accepted");
  // Well-formed parameter is acknowledged and held for the commit
  param_ack_a: assert property (good_param_s
    |=> ACK_O && param_ff == $past(BYTE_I.data[3:0]))
    else $error("valid parameter not acknowledged");
  // Setup register and read data follow the held parameter at the edge
  commit_upd_a: assert property (commit_s
    |=> RD_DATA_O == {4'h0, $past(param_ff)}
    && LINE_SPEED_SELECT_O == $past(param_ff[DCW_POS_SPEED]))
    else $error("setup register not updated at ack edge");
  // Commit clears the indicator and points the reader at the setup register
  commit_side_a: assert property (commit_s
    |=> !RESET_IND_O && READ_PTR_O == DCW_PTR_CFG)
    else $error("reset indicator or read pointer wrong after write");
  // Nothing is stored before the acknowledge edge
  no_early_a: assert property ((state_ff == ST_COMMIT && !ACK_EDGE_I && !DEV_RESET_I)
    |=> $stable(cfg_ff))
    else $error("settings changed before ack edge");
  // Device reset restores defaults
  dev_reset_a: assert property (DEV_RESET_I
    |=> RD_DATA_O == 8'h00 && RESET_IND_O && !ACK_O)
    else $error("device reset did not restore defaults");
  // Outside a commit and a device reset the settings, pointer and indicator hold
  cfg_hold_a: assert property ((!(state_ff == ST_COMMIT && ACK_EDGE_I)
    && !DEV_RESET_I) |=> $stable(cfg_ff))
    else $error("settings changed outside a commit");
  ptr_hold_a: assert property ((!(state_ff == ST_COMMIT && ACK_EDGE_I)
    && !DEV_RESET_I) |=> $stable(READ_PTR_O))
    else $error("read pointer moved outside a commit");
  ind_hold_a: assert property ((!(state_ff == ST_COMMIT && ACK_EDGE_I)
    && !DEV_RESET_I) |=> $stable(RESET_IND_O))
    else $error("reset indicator changed outside a write");
  // Acknowledge falls at its edge when no new byte arrives
  ack_drop_a: assert property ((ACK_EDGE_I && !BYTE_VALID_I && !DEV_RESET_I) |=> !ACK_O)
    else $error("acknowledge held past its edge");
  // Stop closes a refused command
  drop_exit_a: assert property ((state_ff == ST_DROP && STOP_I && !DEV_RESET_I)
    |=> state_ff == ST_IDLE)
    else $error("refused command not closed by stop");

endmodule : dcw_cfg_write
`default_nettype wire

// ===== logic/dcw_pkg.sv
// Constants and types for the configuration write command handler
`default_nettype none
package dcw_pkg;
  // Command code and read pointer codes
  localparam logic [7:0] DCW_CMD_WRITE_CFG = 8'hD2;
  localparam logic [7:0] DCW_PTR_CFG = 8'hC3;
  localparam logic [7:0] DCW_PTR_STATUS = 8'hF0;
  // Field positions inside the stored configuration nibble
  localparam int DCW_POS_ACT_PULLUP = 0;
  localparam int DCW_POS_PWR_DOWN = 1;
  localparam int DCW_POS_STRONG_PULLUP = 2;
  localparam int DCW_POS_SPEED = 3;
  // Reset values
  localparam logic [3:0] DCW_CFG_RESET = 4'h0;
  localparam logic DCW_RST_IND_RESET = 1'b1;
  localparam logic [3:0] DCW_READ_UPPER = 4'h0;

  // Stored settings, bit 3 down to bit 0
  typedef struct packed {
    logic line_speed_select;
    logic strong_pullup_enable;
    logic port_power_down;
    logic active_pullup_enable;
  } dcw_cfg_type;

  // One received byte from the serial host layer
  typedef struct packed {
    logic is_cmd;
    logic [7:0] data;
  } dcw_byte_type;
endpackage : dcw_pkg
`default_nettype wire

// ===== sim/dcw_host_model.sv
// Byte-level host master model driving the configuration write handler
`timescale 1ns/1ps
`default_nettype none
module dcw_host_model
  import dcw_pkg::*;
(
  // Clock and acknowledge from the device
  input wire logic clk_i,
  input wire logic ack_i,
  // Byte stream towards the device
  output logic byte_valid_o,
  output var dcw_byte_type byte_o,
  output logic ack_edge_o,
  output logic stop_o
);
  // Idle bus at time zero
  initial begin
    byte_valid_o = 1'b0;
    byte_o = '0;
    ack_edge_o = 1'b0;
    stop_o = 1'b0;
  end
  // One byte then its acknowledge bit, ack level sampled before the edge
  task automatic send(input logic is_cmd, input logic [7:0] data, output logic ack);
    @(negedge clk_i);
    byte_valid_o = 1'b1;
    byte_o = {is_cmd, data};
    @(negedge clk_i);
    byte_valid_o = 1'b0;
    byte_o = {~is_cmd, ~data}; // Released byte never repeats its value
    @(negedge clk_i);
    ack = ack_i;
    ack_edge_o = 1'b1;
    @(negedge clk_i);
    ack_edge_o = 1'b0;
  endtask : send
  // Stop condition ends the transaction
  task automatic end_xfer();
    @(negedge clk_i);
    stop_o = 1'b1;
    @(negedge clk_i);
    stop_o = 1'b0;
  endtask : end_xfer
  // Code byte, one parameter byte, then stop
  task automatic wr(input logic [7:0] data, output logic a0, output logic a1);
    send(1'b1, DCW_CMD_WRITE_CFG, a0);
    send(1'b0, data, a1);
    end_xfer();
  endtask : wr
endmodule : dcw_host_model
`default_nettype wire

// ===== sim/dcw_cfg_write_tb_top.sv
// Self-checking testbench for the configuration write handler
`timescale 1ns/1ps
`default_nettype none
module dcw_cfg_write_tb_top;
  import dcw_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic dev_rst = 1'b0;
  logic busy = 1'b0;
  logic ack, bv, ae, stp, ws, strong_pu, pwr_dn, act_pu, ri, a0, a1;
  dcw_byte_type bt;
  logic [7:0] ptr, rd;
  int failures = 0;
  int checks = 0;
  // Free-running clock
  initial begin
    forever #5 clk = ~clk;
  end
  dcw_host_model i_host (.clk_i(clk), .ack_i(ack), .byte_valid_o(bv), .byte_o(bt),
    .ack_edge_o(ae), .stop_o(stp));
  dcw_cfg_write i_dut (.CLK_I(clk), .RESET_N_I(rst_n), .BYTE_VALID_I(bv), .BYTE_I(bt),
    .ACK_EDGE_I(ae), .STOP_I(stp), .ACK_O(ack), .DEV_RESET_I(dev_rst), .WIRE_BUSY_I(busy),
    .LINE_SPEED_SELECT_O(ws), .STRONG_PULLUP_ENABLE_O(strong_pu), .PORT_POWER_DOWN_O(pwr_dn),
    .ACTIVE_PULLUP_ENABLE_O(act_pu), .RESET_IND_O(ri), .READ_PTR_O(ptr), .RD_DATA_O(rd));
  // Counted comparison with a one-line report on mismatch
  task automatic chk(input string what, input logic [20:0] exp, input logic [20:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Visible state: pointer, read data, indicator, settings
  function automatic logic [20:0] st();
    return {ptr, rd, ri, ws, strong_pu, pwr_dn, act_pu};
  endfunction : st
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  // Every nibble value written and read back
  task automatic test_writes();
    logic [3:0] v;
    for (int i = 0; i < 16; i++) begin
      v = 4'(i);
      i_host.wr({~v, v}, a0, a1);
      chk("write acks", 21'h3, 21'({a0, a1}));
      chk("setup", {DCW_PTR_CFG, DCW_READ_UPPER, v, 1'b0, v}, st());
    end
    $display("test_writes done");
  endtask : test_writes
  // Broken integrity byte then busy wire, both leave settings alone
  task automatic test_refused();
    i_host.wr(8'h55, a0, a1);
    chk("bad byte acks", 21'h2, 21'({a0, a1}));
    chk("bad byte kept", {DCW_PTR_CFG, 8'h0F, 1'b0, 4'hF}, st());
    @(negedge clk);
    busy = 1'b1;
    i_host.wr(8'hA5, a0, a1);
    busy = 1'b0; // Wire goes idle again once the refused write ends
    chk("busy acks", 21'h0, 21'({a0, a1}));
    chk("busy kept", {DCW_PTR_CFG, 8'h0F, 1'b0, 4'hF}, st());
    $display("test_refused done");
  endtask : test_refused
  // Device reset command clears settings and sets indicator
  task automatic test_dev_reset();
    @(negedge clk);
    dev_rst = 1'b1;
    @(negedge clk);
    dev_rst = 1'b0;
    @(negedge clk);
    chk("dev reset", {DCW_PTR_STATUS, 8'h00, 1'b1, 4'h0}, st());
    $display("test_dev_reset done");
  endtask : test_dev_reset
  // Foreign code and a code byte in the parameter slot write nothing
  task automatic test_ignored();
    i_host.send(1'b1, 8'hE1, a0);
    i_host.send(1'b0, 8'h3C, a1);
    i_host.end_xfer();
    chk("foreign acks", 21'h0, 21'({a0, a1}));
    i_host.send(1'b1, DCW_CMD_WRITE_CFG, a0);
    i_host.send(1'b1, 8'h3C, a1);
    i_host.end_xfer();
    chk("code as param acks", 21'h2, 21'({a0, a1}));
    chk("ignored kept", {DCW_PTR_STATUS, 8'h00, 1'b1, 4'h0}, st());
    $display("test_ignored done");
  endtask : test_ignored
  // Reset pin in mid-run, then a device reset landing on a commit edge
  task automatic test_in_flight();
    i_host.wr(8'h96, a0, a1);
    chk("write 96", {DCW_PTR_CFG, 8'h06, 1'b0, 4'h6}, st());
    @(negedge clk);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk("pin reset", {DCW_PTR_STATUS, 8'h00, 1'b1, 4'h0}, st());
    i_host.wr(8'h96, a0, a1);
    chk("rewrite 96", {DCW_PTR_CFG, 8'h06, 1'b0, 4'h6}, st());
    fork
      i_host.wr(8'h87, a0, a1);
      begin
        repeat (7) @(negedge clk);
        dev_rst = 1'b1; // Lands with the parameter acknowledge edge
        @(negedge clk);
        dev_rst = 1'b0;
      end
    join
    chk("reset wins acks", 21'h3, 21'({a0, a1}));
    chk("reset wins", {DCW_PTR_STATUS, 8'h00, 1'b1, 4'h0}, st());
    $display("test_in_flight done");
  endtask : test_in_flight
  // Main sequence
  initial begin
    repeat (8) @(negedge clk);
    chk("por state", {DCW_PTR_STATUS, 8'h00, 1'b1, 4'h0}, st());
    rst_n = 1'b1;
    test_writes();
    test_refused();
    test_dev_reset();
    test_ignored();
    test_in_flight();
    finish_test();
  end
  // Watchdog against a hang
  initial begin
    #100us;
    failures++;
    finish_test();
  end
endmodule : dcw_cfg_write_tb_top
`default_nettype wire
